// file: pkg/pbs_regs.vh
// Constants shared by the pipelined burst SRAM port design.
`ifndef PBS_REGS_VH
`define PBS_REGS_VH
`define PBS_ADDR_W      17
`define PBS_DATA_W      32
`define PBS_PAR_W       4
`define PBS_LANES       4
`define PBS_LANE_W      8
`define PBS_FIFO_DEPTH  4
`define PBS_FIFO_AW     2
`define PBS_ORDER_LIN   1'h0
`define PBS_ORDER_ILV   1'h1
`define PBS_LANES_ALL   4'hF
`define PBS_LANES_NONE  4'h0
`endif

// file: tb/pbs_bus_model.sv
// Controller side of the shared 36-bit data pins.
`timescale 1ns/1ps
`default_nettype none
module pbs_bus_model (
	input  wire logic        mclk,
	input  wire logic        drive,
	input  wire logic [35:0] value,
	input  wire logic        dev_oe,
	input  wire logic [35:0] dev_value,
	output var  logic [35:0] pins
);
	logic [35:0] last = 36'h0;  // Level seen at the previous edge.
	// One direction for all 36 lines; a released bus keeps changing.
	always_comb begin
		if (dev_oe)
			pins = dev_value;
		else if (drive)
			pins = value;
		else
			pins = ~last;
	end
	always @(posedge mclk) last <= pins;
endmodule
`default_nettype wire

// file: tb/pbs_sram_port_bench.sv
// Self-checking bench for the burst SRAM port.
`timescale 1ns/1ps
`default_nettype none
module pbs_sram_port_bench;
	localparam logic [14:0] B = 15'h1234;  // Fixed upper address bits.
	logic mclk = 1'b0, rst = 1'b1, order = 1'b0;
	logic pstb_n, cstb_n, adv_n, gw_n, gate_n, cs1_n, cs2, cs3_n, oe_n, sleep, drv;
	logic [3:0] bsel_n;
	logic [16:0] addr = 17'h0;
	logic [35:0] val = 36'h0, pins, mem[4];
	logic [31:0] dout;
	logic [3:0] pout;
	logic oe, poe, wr_rdy, slp;
	int err_count = 0, compares = 0;
	pbs_sram_port i_dut (.mclk(mclk), .rst(rst), .addr(addr), .processor_addr_strobe_n(pstb_n),
		.controller_addr_strobe_n(cstb_n), .burst_advance_n(adv_n), .all_bytes_write_n(gw_n),
		.byte_write_gate_n(gate_n), .byte_write_sel_n(bsel_n), .chip_sel_first_n(cs1_n),
		.chip_sel_second(cs2), .chip_sel_third_n(cs3_n), .output_enable_n(oe_n),
		.sleep_request(sleep), .burst_order(order), .data_in(pins[31:0]), .data_out(dout),
		.data_oe(oe), .parity_lines_in(pins[35:32]), .parity_lines_out(pout),
		.parity_lines_oe(poe), .write_ready(wr_rdy), .sleep_active(slp));
	pbs_bus_model i_bus (.mclk(mclk), .drive(drv), .value(val), .dev_oe(oe),
		.dev_value({pout, dout}), .pins(pins));
	always #5 mclk = ~mclk;
	task chk(input logic [35:0] got, input logic [35:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task step;
		@(negedge mclk);
	endtask
	// Quiet pins: selected, output enabled, no strobe and no write.
	task idle;
		{pstb_n, cstb_n, adv_n, gw_n, gate_n, bsel_n} = 9'h1FF;
		{cs1_n, cs2, cs3_n, oe_n, sleep, drv} = 6'h10;
	endtask
	// One strobed access at low address bits lo, then a spare edge.
	// The spare edge keeps the outputs off so the next write owns the pins.
	task go(input logic [1:0] lo, input logic p_n);
		addr = {B, lo};
		cstb_n = 1'b0;
		pstb_n = p_n;
		step;
		idle;
		oe_n = 1'b1;
		step;
	endtask
	task do_reset(input logic o);
		idle;
		rst = 1'b1;
		order = o;
		repeat (4) step;
		rst = 1'b0;
		step;
		chk({pout, dout}, 36'h0);
		chk({32'h0, oe, wr_rdy, slp, poe}, 36'h4);
	endtask
	// Global writes, a byte write, a refused byte write, a priority case.
	task t_fill;
		for (int i = 0; i < 4; i++) begin
			mem[i] = 36'h5_A5C3_0F00 + 36'(i);
			idle;
			gw_n = 1'b0;
			drv = 1'b1;
			val = mem[i];
			chk({35'h0, wr_rdy}, 36'h1);
			go(i[1:0], 1'b1);
		end
		{gate_n, bsel_n, drv, val} = {5'h0A, 1'b1, 36'hF_FFFF_FFFF};
		mem[1] = mem[1] | 36'h5_00FF_00FF;
		go(2'h1, 1'b1);
		{bsel_n, drv, val} = {4'h0, 1'b1, 36'h0};
		go(2'h2, 1'b1);
		{gw_n, drv, val} = {1'b0, 1'b1, 36'h0};
		go(2'h3, 1'b0);
	endtask
	// Deselect, then a four-word burst read from start s.
	task t_burst(input logic [1:0] s, input logic ord);
		logic [1:0] w;
		idle;
		cs2 = 1'b0;
		cstb_n = 1'b0;
		step;
		idle;
		addr = {B, s};
		cstb_n = 1'b0;
		step;
		for (int k = 0; k < 4; k++) begin
			// Word k of the burst stands now; the edge below steps to k+1.
			w = ord ? s ^ k[1:0] : s + k[1:0];
			chk({pout, dout}, mem[w]);
			chk({35'h0, oe}, {35'h0, k != 0});
			idle;
			adv_n = 1'b0;
			pstb_n = k != 2;
			cs1_n = k == 2;
			step;
		end
		// Fourth step wraps back to the starting word.
		chk({pout, dout}, mem[s]);
	endtask
	task t_sleep;
		logic [35:0] held;
		held = {pout, dout};
		idle;
		adv_n = 1'b0;
		sleep = 1'b1;
		step;
		chk({pout, dout}, held);
		chk({34'h0, oe, slp}, 36'h1);
		idle;
		step;
	endtask
	task give_verdict;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		do_reset(1'b0);
		t_fill;
		t_burst(2'h2, 1'b0);
		t_sleep;
		do_reset(1'b1);
		t_fill;
		t_burst(2'h1, 1'b1);
		give_verdict;
	end
	initial begin
		#20000;
		err_count++;
		give_verdict;
	end
endmodule
`default_nettype wire

// file: tb/pbs_sram_port_checker.sv
// Pin-level assertions for the burst SRAM port.
`timescale 1ns/1ps
`default_nettype none
module pbs_sram_port_checker (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        processor_addr_strobe_n,
	input wire logic        controller_addr_strobe_n,
	input wire logic        all_bytes_write_n,
	input wire logic        byte_write_gate_n,
	input wire logic [3:0]  byte_write_sel_n,
	input wire logic        chip_sel_first_n,
	input wire logic        chip_sel_second,
	input wire logic        chip_sel_third_n,
	input wire logic        output_enable_n,
	input wire logic        sleep_request,
	input wire logic [31:0] data_out,
	input wire logic        data_oe,
	input wire logic        parity_lines_oe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Decoded selection, accepted strobe and a read-only edge.
	wire sel = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
	wire stb = !controller_addr_strobe_n || (!processor_addr_strobe_n && !chip_sel_first_n);
	wire desel = !sleep_request && stb && !sel;
	wire acc = !sleep_request && stb && sel;
	wire nowr = all_bytes_write_n && (byte_write_gate_n || &byte_write_sel_n);
	wire bread = !sleep_request && controller_addr_strobe_n && nowr && !output_enable_n;
	property p_oe_pair; data_oe == parity_lines_oe; endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
	property p_oen_off; output_enable_n |=> !data_oe; endproperty
	a_oen_off: assert property (p_oen_off) else $error("driving while disabled");
	property p_oe_hold;
		data_oe && bread && (processor_addr_strobe_n || chip_sel_first_n) |=> data_oe;
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("burst read lost drive");
	property p_desel; desel |=> !data_oe; endproperty
	a_desel: assert property (p_desel) else $error("driving after deselect");
	property p_first; desel ##1 acc |=> !data_oe; endproperty
	a_first: assert property (p_first) else $error("first read not masked");
	property p_sleep_off; sleep_request |=> !data_oe; endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("driving in sleep");
	property p_sleep_hold; sleep_request |=> $stable(data_out); endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("data moved in sleep");
	property p_wr_off;
		!sleep_request && !all_bytes_write_n && processor_addr_strobe_n |=> !data_oe;
	endproperty
	a_wr_off: assert property (p_wr_off) else $error("driving during write");
	c_first: cover property (desel ##1 acc);
	c_hold: cover property (data_oe ##1 data_oe);
	c_sleep: cover property (sleep_request);
endmodule
bind pbs_sram_port pbs_sram_port_checker i_chk (.mclk, .rst, .processor_addr_strobe_n,
	.controller_addr_strobe_n, .all_bytes_write_n, .byte_write_gate_n, .byte_write_sel_n,
	.chip_sel_first_n, .chip_sel_second, .chip_sel_third_n, .output_enable_n,
	.sleep_request, .data_out, .data_oe, .parity_lines_oe);
`default_nettype wire

// file: verilog/pbs_fifo.v
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module pbs_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             clk,
	input  wire             rst,
	input  wire             in_valid,
	output reg              in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg  [WIDTH-1:0] store [0:DEPTH-1]; // Word storage.
	reg  [AW-1:0]    wr_ptr;            // Next slot to fill.
	reg  [AW-1:0]    rd_ptr;            // Oldest slot.
	reg  [AW:0]      count;             // Words held.
	wire             push;
	wire             pop;
	reg  [AW:0]      next_count;

	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = store[rd_ptr];

	// Next occupancy from this cycle's push and pop.
	always @* begin
		next_count = count;
		if (push & ~pop) begin
			next_count = count + 1'b1;
		end else if (pop & ~push) begin
			next_count = count - 1'b1;
		end
	end

	// Pointers, count and a registered ready that is honest about full.
	always @(posedge clk) begin
		if (rst) begin
			wr_ptr   <= {AW{1'b0}};
			rd_ptr   <= {AW{1'b0}};
			count    <= {(AW+1){1'b0}};
			in_ready <= 1'b1;
		end else begin
			if (push) begin
				store[wr_ptr] <= in_data;
				wr_ptr        <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			end
			count    <= next_count;
			in_ready <= (next_count != DEPTH[AW:0]);
		end
	end
endmodule
`default_nettype wire

// file: verilog/pbs_sram_port.v
// Pipelined burst SRAM with common data pins, strobes and burst counter.
//
// Overview of operation
// - Capture address on strobe with chip selected.
// - Load low address bits into burst counter.
// - Byte selects write only with byte gate.
// - Global write writes all bytes, ignoring others.
// - Advance input low steps the burst counter.
// - Selected when first,third low, second high.
// - Processor strobe ignored when first enable high.
// - Processor strobe wins over controller strobe.
// - Output enable low drives pins, else inputs.
// - First read after deselect keeps outputs off.
// - Sleep input halts activity, keeps stored data.
// - Input data pins registered on clock edge.
// - Read data appears one clock after address.
// - Thirty-two data plus four parity, one direction.
// - Order strap: low linear, high interleaved.
// - Processor strobe write ignores controls first clock.
`timescale 1ns/1ps
`default_nettype none
`include "pbs_regs.vh"
module pbs_sram_port #(
	parameter ADDR_W = `PBS_ADDR_W,
	parameter DATA_W = `PBS_DATA_W,
	parameter PAR_W  = `PBS_PAR_W
) (
	input  wire              mclk,
	input  wire              rst,
	input  wire [ADDR_W-1:0] addr,
	input  wire              processor_addr_strobe_n,
	input  wire              controller_addr_strobe_n,
	input  wire              burst_advance_n,
	input  wire              all_bytes_write_n,
	input  wire              byte_write_gate_n,
	input  wire [3:0]        byte_write_sel_n,
	input  wire              chip_sel_first_n,
	input  wire              chip_sel_second,
	input  wire              chip_sel_third_n,
	input  wire              output_enable_n,
	input  wire              sleep_request,
	input  wire              burst_order,
	input  wire [DATA_W-1:0] data_in,
	output reg  [DATA_W-1:0] data_out,
	output reg               data_oe,
	input  wire [PAR_W-1:0]  parity_lines_in,
	output reg  [PAR_W-1:0]  parity_lines_out,
	output reg               parity_lines_oe,
	output wire              write_ready,
	output reg               sleep_active
);
	localparam WORD_W = DATA_W + PAR_W;          // One stored word with parity.
	localparam ENT_W  = ADDR_W + WORD_W + 4;     // Queued write entry.
	localparam DEPTH  = 1 << ADDR_W;             // Words in the array.

	reg  [DATA_W-1:0] mem_data [0:DEPTH-1];      // Data storage.
	reg  [PAR_W-1:0]  mem_par  [0:DEPTH-1];      // Parity storage.

	reg  [ADDR_W-1:0] addr_reg;      // Captured base address.
	reg  [1:0]        start_lsb;     // Burst starting point.
	reg  [1:0]        burst_cnt;     // Steps taken within the burst.
	reg               active;        // Selected with a burst open.
	reg               processor_addr_strobe_n_first;    // Last edge opened a processor strobe access.
	reg               order_mode;    // Burst order caught after reset.
	reg               order_caught;  // Strap already sampled.
	reg               out_mask;      // First read after deselect is masked.

	// Selection decode and strobe priority.
	wire sel_ok;
	wire processor_addr_strobe_n_seen;
	wire controller_addr_strobe_n_seen;
	assign sel_ok    = ~chip_sel_first_n & chip_sel_second & ~chip_sel_third_n;
	assign processor_addr_strobe_n_seen = ~processor_addr_strobe_n & ~chip_sel_first_n;
	assign controller_addr_strobe_n_seen = ~controller_addr_strobe_n & ~processor_addr_strobe_n_seen;

	// Byte lanes asked for by the write controls at this edge.
	wire [3:0] lanes_req;
	assign lanes_req = ~all_bytes_write_n ? `PBS_LANES_ALL :
		(~byte_write_gate_n ? ~byte_write_sel_n : `PBS_LANES_NONE);

	// Burst address bits for a given step, wrapping inside four words.
	function [1:0] burst_lsb;
		input [1:0] start;
		input [1:0] step;
		input       order;
		begin
			if (order == `PBS_ORDER_LIN) begin
				burst_lsb = start + step;
			end else begin
				burst_lsb = start ^ step;
			end
		end
	endfunction

	// Decision for this edge, worked out combinationally.
	reg              next_load;      // Take a new address.
	reg              next_active;    // Burst open after this edge.
	reg [1:0]        next_cnt;       // Counter after this edge.
	reg [ADDR_W-1:0] acc_addr;       // Word touched at this edge.
	reg              do_read;        // Fetch into the output register.
	reg [3:0]        wr_lanes;       // Lanes written at this edge.
	reg              next_mask;      // Mask for the fetched word.

	always @* begin
		next_load   = 1'b0;
		next_active = active;
		next_cnt    = burst_cnt;
		acc_addr    = {addr_reg[ADDR_W-1:2], burst_lsb(start_lsb, burst_cnt, order_mode)};
		do_read     = 1'b0;
		wr_lanes    = `PBS_LANES_NONE;
		next_mask   = out_mask;
		if (sleep_request) begin
			// Asleep: nothing sampled, nothing touched.
			next_active = active;
		end else if (processor_addr_strobe_n_seen) begin
			// Processor strobe opens an access; write controls wait a clock.
			if (sel_ok) begin
				next_load   = 1'b1;
				next_active = 1'b1;
				next_cnt    = 2'h0;
				acc_addr    = addr;
				do_read     = 1'b1;
				next_mask   = ~active;
			end else begin
				next_active = 1'b0;
			end
		end else if (controller_addr_strobe_n_seen) begin
			// Controller strobe: write controls act on this very edge, else a read.
			if (sel_ok) begin
				next_load   = 1'b1;
				next_active = 1'b1;
				next_cnt    = 2'h0;
				acc_addr    = addr;
				wr_lanes    = lanes_req;
				do_read     = (lanes_req == `PBS_LANES_NONE);
				next_mask   = ~active;
			end else begin
				next_active = 1'b0;
			end
		end else if (active) begin
			// Continuation of an open burst.
			if (processor_addr_strobe_n_first) begin
				// Data of a processor strobe write lands at the base word.
				wr_lanes = lanes_req;
				do_read  = (lanes_req == `PBS_LANES_NONE);
			end else if (lanes_req != `PBS_LANES_NONE) begin
				// Write at the current word, then step if asked.
				wr_lanes = lanes_req;
				if (~burst_advance_n) begin
					next_cnt = burst_cnt + 1'b1;
				end
			end else begin
				// Read: step first, then fetch the new word.
				if (~burst_advance_n) begin
					next_cnt = burst_cnt + 1'b1;
					acc_addr = {addr_reg[ADDR_W-1:2],
						burst_lsb(start_lsb, next_cnt, order_mode)};
				end
				do_read   = 1'b1;
				next_mask = 1'b0;
			end
		end
	end

	// Write queue between the pins and the array.
	wire             q_out_valid;
	wire [ENT_W-1:0] q_out_data;
	wire             q_drain;
	wire             q_push;
	assign q_push  = (wr_lanes != `PBS_LANES_NONE);
	assign q_drain = ~sleep_request;   // The array stops while asleep.

	pbs_fifo #(
		.WIDTH (ENT_W),
		.DEPTH (`PBS_FIFO_DEPTH),
		.AW    (`PBS_FIFO_AW)
	) u_wq (
		.clk       (mclk),
		.rst       (rst),
		.in_valid  (q_push),
		.in_ready  (write_ready),
		.in_data   ({acc_addr, parity_lines_in, data_in, wr_lanes}),
		.out_valid (q_out_valid),
		.out_ready (q_drain),
		.out_data  (q_out_data)
	);

	// Fields of the entry leaving the queue.
	wire [ADDR_W-1:0] w_addr;
	wire [PAR_W-1:0]  w_par;
	wire [DATA_W-1:0] w_data;
	wire [3:0]        w_lanes;
	assign w_addr  = q_out_data[ENT_W-1:WORD_W+4];
	assign w_par   = q_out_data[WORD_W+3:DATA_W+4];
	assign w_data  = q_out_data[DATA_W+3:4];
	assign w_lanes = q_out_data[3:0];

	// Array write, one byte lane plus its parity bit per select.
	integer i;
	always @(posedge mclk) begin
		if (q_out_valid & q_drain) begin
			for (i = 0; i < `PBS_LANES; i = i + 1) begin
				if (w_lanes[i]) begin
					mem_data[w_addr][i*`PBS_LANE_W +: `PBS_LANE_W] <=
						w_data[i*`PBS_LANE_W +: `PBS_LANE_W];
					mem_par[w_addr][i] <= w_par[i];
				end
			end
		end
	end

	// Burst state, address register and strap capture.
	always @(posedge mclk) begin
		if (rst) begin
			addr_reg     <= {ADDR_W{1'b0}};
			start_lsb    <= 2'h0;
			burst_cnt    <= 2'h0;
			active       <= 1'b0;
			processor_addr_strobe_n_first   <= 1'b0;
			order_mode   <= `PBS_ORDER_ILV;
			order_caught <= 1'b0;
			out_mask     <= 1'b1;
			sleep_active <= 1'b0;
		end else begin
			if (~order_caught) begin
				order_mode   <= burst_order;
				order_caught <= 1'b1;
			end
			if (next_load) begin
				addr_reg  <= addr;
				start_lsb <= addr[1:0];
			end
			burst_cnt    <= next_cnt;
			active       <= next_active;
			processor_addr_strobe_n_first   <= ~sleep_request & processor_addr_strobe_n_seen & sel_ok;
			out_mask     <= next_mask;
			sleep_active <= sleep_request;
		end
	end

	// Output register: the fetched word shows one clock after its address.
	always @(posedge mclk) begin
		if (rst) begin
			data_out         <= {DATA_W{1'b0}};
			parity_lines_out <= {PAR_W{1'b0}};
		end else if (do_read) begin
			data_out         <= mem_data[acc_addr];
			parity_lines_out <= mem_par[acc_addr];
		end
	end

	// Pin direction: both groups share one enable from one decision.
	wire drive_now;
	assign drive_now = do_read & ~output_enable_n & ~next_mask & next_active;
	always @(posedge mclk) begin
		if (rst) begin
			data_oe         <= 1'b0;
			parity_lines_oe <= 1'b0;
		end else begin
			data_oe         <= drive_now;
			parity_lines_oe <= drive_now;
		end
	end
endmodule
`default_nettype wire
